// ==== hdl/stm_pkg.sv ====
// constants shared by the step timing block and its unit timer
package stm_pkg;

	// register offsets on the byte register port
	localparam logic [7:0] REG_CCW_PW_LO  = 8'h18;
	localparam logic [7:0] REG_CCW_PW_HI  = 8'h19;
	localparam logic [7:0] REG_CW_STEP_LO = 8'h1A;
	localparam logic [7:0] REG_CW_STEP_HI = 8'h1B;
	localparam logic [7:0] REG_CCW_STEP_LO = 8'h1C;
	localparam logic [7:0] REG_CCW_STEP_HI = 8'h1D;
	localparam logic [7:0] REG_CW_ROT_LO  = 8'h1E;
	localparam logic [7:0] REG_CW_ROT_HI  = 8'h1F;
	localparam int         REG_COUNT      = 8;
	localparam logic [7:0] REG_RESET      = 8'h00;

	// pulse width word layout
	localparam int PRESCALE_MSB = 15;
	localparam int PRESCALE_LSB = 13;
	localparam int WIDTH_MSB    = 12;
	localparam logic [12:0] WIDTH_MAX = 13'h1FFF;

	// timing: system clock, nominal internal clock, smallest width unit
	localparam int SYS_PERIOD_NS  = 25;
	localparam int BASE_PERIOD_NS = 1000;
	localparam int BASE_CYCLES    = BASE_PERIOD_NS / SYS_PERIOD_NS;
	localparam int MIN_UNIT_NS    = 3000;
	localparam int MIN_UNIT_TICKS = MIN_UNIT_NS / BASE_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCEL,
		ST_RUN,
		ST_DECEL
	} stm_state_t;

endpackage : stm_pkg

// ==== hdl/stm_unit_timer.sv ====
// width unit tick generator: 3 us scaled by two to the prescaler
`timescale 1ns/10ps
module stm_unit_timer (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// control
	input  wire logic       en_i,
	input  wire logic [2:0] prescale_i,
	// tick out
	output logic            unit_tick_o
);

	logic [5:0]  base_cnt;
	logic [9:0]  sub_cnt;
	logic [9:0]  sub_last;
	logic        base_wrap;
	logic [15:0] gap;
	logic        gap_valid;
	logic [2:0]  prev_prescale;

	// 1 MHz internal clock from the 40 MHz system clock
	assign base_wrap = base_cnt == 6'(stm_pkg::BASE_CYCLES - 1);
	assign sub_last  = (10'(stm_pkg::MIN_UNIT_TICKS) << prescale_i)
		- 10'h001;
	assign unit_tick_o = en_i && base_wrap && sub_cnt == sub_last;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_cnt <= 6'h00;
		end else if (!en_i || base_wrap) begin
			base_cnt <= 6'h00;
		end else begin
			base_cnt <= base_cnt + 6'h01;
		end
	end

	// a lowered prescaler mid-unit can leave sub_cnt past the end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sub_cnt <= 10'h000;
		end else if (!en_i || (base_wrap && sub_cnt >= sub_last)) begin
			sub_cnt <= 10'h000;
		end else if (base_wrap) begin
			sub_cnt <= sub_cnt + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap           <= 16'h0000;
			gap_valid     <= 1'b0;
			prev_prescale <= 3'h0;
		end else begin
			prev_prescale <= prescale_i;
			gap <= unit_tick_o ? 16'h0000 : gap + 16'h0001;
			if (!en_i || prescale_i != prev_prescale) begin
				gap_valid <= 1'b0;
			end else if (unit_tick_o) begin
				gap_valid <= 1'b1;
			end
		end
	end

	a_unit_spacing: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		unit_tick_o |=> !unit_tick_o [*8])
		else $error("unit ticks closer than nine cycles");

	a_scale_gap: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(unit_tick_o && gap_valid && prescale_i == prev_prescale)
		|-> gap == (16'h0078 << prescale_i) - 16'h0001)
		else $error("width unit not 120 cycles times two to D");

endmodule : stm_unit_timer

// ==== hdl/stm_step_timing.sv ====
// step timing, ramp and move count registers of the motor controller
`timescale 1ns/10ps
module stm_step_timing (
	// clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_N_I,
	// byte register port from the serial front end
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [7:0]  REG_WDATA_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	output logic      [7:0]  REG_RDATA_O,
	output logic             REG_HIT_O,
	// motion control from neighbouring blocks
	input  wire logic        RUN_I,
	input  wire logic        DIR_CCW_I,
	input  wire logic        RAMP_EN_I,
	input  wire logic [15:0] CW_PULSE_WIDTH_I,
	// step timing out
	output logic             STEP_O,
	output logic             STEP_DIR_CCW_O,
	output logic             BUSY_O,
	output logic      [12:0] CUR_WIDTH_O,
	// register contents for the sequencer
	output logic      [15:0] CCW_PULSE_WIDTH_O,
	output logic      [15:0] CW_STEP_COUNT_O,
	output logic      [15:0] CCW_STEP_COUNT_O,
	output logic      [15:0] CW_ROT_COUNT_O
);

	logic [7:0]          reg_file [stm_pkg::REG_COUNT];
	logic [2:0]          reg_idx;
	logic                reg_hit;
	logic [15:0]         act_pw;
	logic [2:0]          prescale;
	logic [12:0]         target;
	logic                unit_tick;
	logic                interval_done;
	logic                step_pulse;
	logic [12:0]         unit_cnt;
	logic [12:0]         cur_width;
	logic [12:0]         next_cur_width;
	stm_pkg::stm_state_t state;
	stm_pkg::stm_state_t next_state;

	////////////////////////////////////////////////////////////////////
	// register file
	assign reg_hit = REG_ADDR_I >= stm_pkg::REG_CCW_PW_LO
		&& REG_ADDR_I <= stm_pkg::REG_CW_ROT_HI;
	assign reg_idx = 3'(REG_ADDR_I - stm_pkg::REG_CCW_PW_LO);

	for (genvar i = 0; i < stm_pkg::REG_COUNT; i++) begin : g_reg
		always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
			if (!RST_N_I) begin
				reg_file[i] <= stm_pkg::REG_RESET;
			end else if (REG_WR_I && reg_hit && reg_idx == 3'(i)) begin
				reg_file[i] <= REG_WDATA_I;
			end
		end
	end

	// unmapped reads answer zero with the hit flag low
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			REG_RDATA_O <= 8'h00;
			REG_HIT_O   <= 1'b0;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= reg_hit ? reg_file[reg_idx] : 8'h00;
			REG_HIT_O   <= reg_hit;
		end
	end

	assign CCW_PULSE_WIDTH_O = {reg_file[1], reg_file[0]};
	assign CW_STEP_COUNT_O   = {reg_file[3], reg_file[2]};
	assign CCW_STEP_COUNT_O  = {reg_file[5], reg_file[4]};
	assign CW_ROT_COUNT_O    = {reg_file[7], reg_file[6]};

	////////////////////////////////////////////////////////////////////
	// active width word and unit timing
	assign act_pw = DIR_CCW_I ? CCW_PULSE_WIDTH_O
		: CW_PULSE_WIDTH_I;
	assign prescale = act_pw[stm_pkg::PRESCALE_MSB:
		stm_pkg::PRESCALE_LSB];
	assign target = act_pw[stm_pkg::WIDTH_MSB:0];

	stm_unit_timer u_unit (
		.clk_i       (SYS_CLK_I),
		.rst_n_i     (RST_N_I),
		.en_i        (state != stm_pkg::ST_IDLE),
		.prescale_i  (prescale),
		.unit_tick_o (unit_tick)
	);

	// interval is cur_width plus one units
	assign interval_done = unit_tick && unit_cnt >= cur_width;
	assign step_pulse = state != stm_pkg::ST_IDLE && interval_done;

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			unit_cnt <= 13'h0000;
		end else if (state == stm_pkg::ST_IDLE || interval_done) begin
			unit_cnt <= 13'h0000;
		end else if (unit_tick) begin
			unit_cnt <= unit_cnt + 13'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// ramp sequencing; ramp width moves only at step boundaries, run width follows target every cycle
	always_comb begin
		next_state     = state;
		next_cur_width = cur_width;
		case (state)
			stm_pkg::ST_IDLE: begin
				if (RUN_I && RAMP_EN_I) begin
					next_state     = stm_pkg::ST_ACCEL;
					next_cur_width = stm_pkg::WIDTH_MAX;
				end else if (RUN_I) begin
					next_state     = stm_pkg::ST_RUN;
					next_cur_width = target;
				end
			end
			stm_pkg::ST_ACCEL: begin
				if (!RUN_I) begin
					next_state = stm_pkg::ST_DECEL;
				end else if (cur_width <= target) begin
					next_state     = stm_pkg::ST_RUN;
					next_cur_width = target;
				end else if (step_pulse) begin
					next_cur_width = cur_width - 13'h0001;
				end
			end
			stm_pkg::ST_RUN: begin
				next_cur_width = target;
				if (!RUN_I && RAMP_EN_I) begin
					next_state = stm_pkg::ST_DECEL;
				end else if (!RUN_I) begin
					next_state = stm_pkg::ST_IDLE;
				end
			end
			stm_pkg::ST_DECEL: begin
				if (step_pulse && cur_width == stm_pkg::WIDTH_MAX) begin
					next_state = stm_pkg::ST_IDLE;
				end else if (step_pulse) begin
					next_cur_width = cur_width + 13'h0001;
				end
			end
			default: begin
				next_state = stm_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state     <= stm_pkg::ST_IDLE;
			cur_width <= 13'h0000;
		end else begin
			state     <= next_state;
			cur_width <= next_cur_width;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			STEP_O         <= 1'b0;
			STEP_DIR_CCW_O <= 1'b0;
		end else begin
			STEP_O <= step_pulse;
			if (step_pulse) begin
				STEP_DIR_CCW_O <= DIR_CCW_I;
			end
		end
	end

	assign BUSY_O      = state != stm_pkg::ST_IDLE;
	assign CUR_WIDTH_O = cur_width;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);

	a_read_back: assert property (
		(REG_WR_I && reg_hit) ##1
		(REG_RD_I && !REG_WR_I && $stable(REG_ADDR_I))
		|=> REG_RDATA_O == $past(REG_WDATA_I, 2))
		else $error("read-back differs from written byte");

	a_ccw_width: assert property (
		(state == stm_pkg::ST_RUN && RUN_I && DIR_CCW_I)
		|=> cur_width == $past(CCW_PULSE_WIDTH_O[12:0]))
		else $error("ccw run width not taken from ccw word");

	a_ramp_start: assert property (
		(state == stm_pkg::ST_IDLE && RUN_I && RAMP_EN_I)
		|=> state == stm_pkg::ST_ACCEL && cur_width == 13'h1FFF)
		else $error("ramp did not start at range maximum");

	a_accel_stop: assert property (
		(state == stm_pkg::ST_ACCEL && !RUN_I) |=> state == stm_pkg::ST_DECEL)
		else $error("stop during ramp-up did not ramp down");

	a_decel_end: assert property (
		(state == stm_pkg::ST_DECEL && step_pulse
		&& cur_width == 13'h1FFF) |=> state == stm_pkg::ST_IDLE)
		else $error("deceleration did not end at range maximum");

	a_accel_down: assert property (
		(state == stm_pkg::ST_ACCEL && RUN_I && step_pulse
		&& cur_width > target) |=> cur_width == $past(cur_width) - 1)
		else $error("acceleration width not decremented");

	a_step_dir: assert property (
		step_pulse |=> STEP_O && STEP_DIR_CCW_O == $past(DIR_CCW_I)
		##1 !STEP_O [*8])
		else $error("step pulse or direction wrong");

	a_cw_count: assert property (
		(REG_WR_I && REG_ADDR_I == stm_pkg::REG_CW_STEP_HI)
		|=> CW_STEP_COUNT_O[15:8] == $past(REG_WDATA_I))
		else $error("cw step count high byte not stored");

	a_ccw_count: assert property (
		(REG_WR_I && REG_ADDR_I == stm_pkg::REG_CCW_STEP_LO)
		|=> CCW_STEP_COUNT_O[7:0] == $past(REG_WDATA_I))
		else $error("ccw step count low byte not stored");

	a_rot_count: assert property (
		(REG_WR_I && REG_ADDR_I == stm_pkg::REG_CW_ROT_HI)
		|=> CW_ROT_COUNT_O[15:8] == $past(REG_WDATA_I))
		else $error("cw rotation count high byte not stored");

	a_idle_quiet: assert property (
		state == stm_pkg::ST_IDLE |=> !STEP_O)
		else $error("step issued while idle");

	c_accel_to_run: cover property (
		state == stm_pkg::ST_ACCEL ##1 state == stm_pkg::ST_RUN);
	c_decel_to_idle: cover property (
		state == stm_pkg::ST_DECEL ##1 state == stm_pkg::ST_IDLE);
	c_ccw_step: cover property (step_pulse && DIR_CCW_I);

endmodule : stm_step_timing

// ==== bench/stm_host_model.sv ====
// host model driving the byte register port of the step timing block
`timescale 1ns/10ps
module stm_host_model (
	// clock
	input  wire logic       clk_i,
	// byte register port
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i,
	input  wire logic       hit_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// rotation moves are never requested, so no steps-per-turn load
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// released lines must not keep showing the last value
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr_byte

	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d,
		output logic h);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
		h = hit_i;
	endtask : rd_byte

	// write a byte, then read it back in the very next cycle
	task automatic wr_rd_byte(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic h);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
		#1;
		q = rdata_i;
		h = hit_i;
	endtask : wr_rd_byte
endmodule : stm_host_model

// ==== bench/stm_step_timing_test.sv ====
// self-checking bench for the step timing and move count block
`timescale 1ns/10ps
module stm_step_timing_test;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        run = 1'b0;
	logic        dir = 1'b0;
	logic        ramp = 1'b0;
	logic [15:0] cw_pw = 16'h0000;
	logic [7:0]  addr, wdata, rdata;
	logic        wr, rd, hit, step, sdir, busy;
	logic [12:0] cur;
	logic [15:0] ccw_pw_o, cw_sc, ccw_sc, cw_rc;
	logic [7:0]  mem [8];
	int          err_total = 0;
	int          compares = 0;
	integer      seed = 32'h538C5BA7;

	always #12.5 clk = ~clk;

	stm_host_model i_stm_host_model (.clk_i(clk), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata), .hit_i(hit));

	stm_step_timing i_stm_step_timing (.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_HIT_O(hit), .RUN_I(run),
		.DIR_CCW_I(dir), .RAMP_EN_I(ramp), .CW_PULSE_WIDTH_I(cw_pw),
		.STEP_O(step), .STEP_DIR_CCW_O(sdir), .BUSY_O(busy),
		.CUR_WIDTH_O(cur), .CCW_PULSE_WIDTH_O(ccw_pw_o),
		.CW_STEP_COUNT_O(cw_sc), .CCW_STEP_COUNT_O(ccw_sc),
		.CW_ROT_COUNT_O(cw_rc));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// cycles between steps: (width+1) units of 3 internal ticks << prescaler
	function automatic int gap(input logic [15:0] pw);
		return (int'(pw[12:0]) + 1) * stm_pkg::BASE_CYCLES
			* stm_pkg::MIN_UNIT_TICKS * (1 << pw[15:13]);
	endfunction : gap

	task automatic check_regs;
		logic [7:0] d;
		logic       h;
		for (int i = 0; i < 8; i++) begin
			i_stm_host_model.rd_byte(8'h18 + 8'(i), d, h);
			chk(d, mem[i]);
			chk(h, 1'b1);
		end
		chk(ccw_pw_o, {mem[1], mem[0]});
		chk(cw_sc, {mem[3], mem[2]});
		chk(ccw_sc, {mem[5], mem[4]});
		chk(cw_rc, {mem[7], mem[6]});
	endtask : check_regs

	task automatic measure(input logic [15:0] pw, input logic d);
		int n;
		if (d) begin
			mem[0] = pw[7:0];
			mem[1] = pw[15:8];
			i_stm_host_model.wr_byte(8'h18, pw[7:0]);
			i_stm_host_model.wr_byte(8'h19, pw[15:8]);
		end else begin
			@(posedge clk);
			cw_pw <= pw;
		end
		@(posedge clk);
		dir <= d;
		run <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (step !== 1'b1 && n < 20000);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (step !== 1'b1 && n < 20000);
		chk(n, gap(pw));
		chk(sdir, d);
		@(posedge clk);
		run <= 1'b0;
		@(posedge clk);
		#1;
		chk(busy, 1'b0);
	endtask : measure

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  d;
		logic        h;
		logic [31:0] r;
		for (int i = 0; i < 8; i++) mem[i] = 8'h00;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		check_regs();
		for (int i = 0; i < 8; i++) begin
			mem[i] = 8'($random(seed));
			i_stm_host_model.wr_byte(8'h18 + 8'(i), mem[i]);
		end
		// unmapped neighbours must neither store nor answer
		i_stm_host_model.wr_byte(8'h17, 8'hA5);
		i_stm_host_model.wr_byte(8'h20, 8'h5A);
		check_regs();
		i_stm_host_model.rd_byte(8'h17, d, h);
		chk({h, d}, 9'h000);
		i_stm_host_model.rd_byte(8'h20, d, h);
		chk({h, d}, 9'h000);
		// a read right behind a write must already see the new byte
		r = $random(seed);
		mem[3] = r[7:0];
		i_stm_host_model.wr_rd_byte(8'h1B, mem[3], d, h);
		chk(d, mem[3]);
		chk(h, 1'b1);
		chk(cw_sc, {mem[3], mem[2]});
		measure(16'hE000, 1'b1);
		for (int k = 0; k < 3; k++) begin
			r = $random(seed);
			measure({1'b0, r[1:0], 11'h000, r[3:2]}, 1'b1);
			measure({1'b0, r[5:4], 11'h000, r[7:6]}, 1'b0);
		end
		@(posedge clk);
		ramp <= 1'b1;
		run <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		#1;
		chk(cur, 13'h1FFF);
		chk(busy, 1'b1);
		// a stop while ramping up must ramp down, not drop to idle
		@(posedge clk);
		run <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(busy, 1'b1);
		chk(cur, 13'h1FFF);
		@(posedge clk);
		rst_n <= 1'b0;
		#1;
		chk(busy, 1'b0);
		chk(cur, 13'h0000);
		chk(cw_sc, 16'h0000);
		chk(ccw_pw_o, 16'h0000);
		chk({step, sdir}, 2'b00);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) mem[i] = 8'h00;
		check_regs();
		give_verdict();
	end

	initial begin
		repeat (95000) @(posedge clk);
		err_total++;
		give_verdict();
	end
endmodule : stm_step_timing_test
